// *** hdl/mctu_regs.vh ***
// Register indices, field positions and reset values of the timer unit.
`ifndef MCTU_REGS_VH
`define MCTU_REGS_VH
// ------------------------------------------------------------------
// Address map: addr[7:4] channel (5 = global), addr[3:0] index
// ------------------------------------------------------------------
`define MCTU_GLOBAL_SEL   4'h5
`define MCTU_CTRL_IDX     4'h0
`define MCTU_IOCTL_IDX    4'h1
`define MCTU_IRQEN_IDX    4'h2
`define MCTU_STAT_IDX     4'h3
`define MCTU_CNT_IDX      4'h4
`define MCTU_GRA_IDX      4'h5
`define MCTU_GRB_IDX      4'h6
`define MCTU_BRA_IDX      4'h7
`define MCTU_BRB_IDX      4'h8
`define MCTU_START_IDX    4'h0
`define MCTU_SYNC_IDX     4'h1
`define MCTU_MODE_IDX     4'h2
`define MCTU_BUFEN_IDX    4'h3
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define MCTU_CK_HI        2
`define MCTU_CK_LO        0
`define MCTU_EDGE_HI      4
`define MCTU_EDGE_LO      3
`define MCTU_CLR_HI       6
`define MCTU_CLR_LO       5
`define MCTU_IOA_CAP      2
`define MCTU_IOB_CAP      6
`define MCTU_FLAG_A       0
`define MCTU_FLAG_B       1
`define MCTU_FLAG_OVF     2
`define MCTU_MODE_PHASE   5
`define MCTU_MODE_RSPWM   6
`define MCTU_MODE_CPWM    7
`define MCTU_BUFB_LO      5
// ------------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------------
`define MCTU_CLR_NONE     2'h0
`define MCTU_CLR_A        2'h1
`define MCTU_CLR_B        2'h2
`define MCTU_CLR_SYNC     2'h3
`define MCTU_OUT_LOW      2'h1
`define MCTU_OUT_HIGH     2'h2
`define MCTU_OUT_TOGGLE   2'h3
`define MCTU_EDGE_RISE    2'h0
`define MCTU_EDGE_FALL    2'h1
`define MCTU_STAT_RSV     16'h0078
`define MCTU_CNT_TOP      16'hFFFF
`define MCTU_CNT_ZERO     16'h0000
`define MCTU_RST_8        8'h00
`define MCTU_RST_16       16'h0000
`endif

// *** hdl/mctu_timer.v ***
// Five-channel 16-bit timer unit with compare, capture and PWM modes.
//
// Contract
// - A counter counts only while its own start bit is 1.
// - After reset counters stay stopped until started; FFFF to 0000 wrap sets overflow.
// - Overflow flag with its enable set raises an interrupt request.
// - Periodic mode: match sets flag, clears counter to 0000.
// - Match/capture flag raises a request only when enabled.
// - Clock source: system clock, or divided by 2, 4 or 8.
// - External clock counts on rising, falling or both edges.
// - Compare drives pin low, high or toggle; channel 2 no toggle.
// - Compare pin holds 0 from configuration until first match.
// - A match asking for the present level leaves the pin alone.
// - Match fires when counter advances past the equal value.
// - Capture copies counter to general register on chosen edges.
// - Writing one synchronized counter writes all synchronized ones.
// - Synchronized-clear channels clear with another's clear source.
// - PWM: A pin goes 1 on match A, 0 on match B.
// - Reset-synced PWM: channels 3, 4 drive six pins off counter 3.
// - Complementary PWM: three non-overlapping pairs, both counters run.
// - Phase counting: channel 2 counts up or down from quadrature.
// - Buffered compare reloads from buffer; capture pushes old value.
// - PWM buffering transfers on reversal or on channel 3 match A.
// - Underflow from 0000 to FFFF also sets the overflow flag.
// - Flags clear by writing 0 after reading 1; writing 1 ignored.
`timescale 1ns/100ps
`include "mctu_regs.vh"
`default_nettype none
module mctu_timer
(
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [3:0]  ext_clock_inputs,
  input  wire [4:0]  compare_capture_pin_a_in,
  output reg  [4:0]  compare_capture_pin_a_out,
  output reg  [4:0]  compare_capture_pin_a_oe,
  input  wire [4:0]  compare_capture_pin_b_in,
  output reg  [4:0]  compare_capture_pin_b_out,
  output reg  [4:0]  compare_capture_pin_b_oe,
  output reg         ch4_inverse_out_a,
  output reg         ch4_inverse_out_b,
  output reg  [14:0] irq_req
);
  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [3:0] sel;
    input [3:0] idx;
    begin
      hit = (a[7:4] == sel) && (a[3:0] == idx);
    end
  endfunction

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------------
  reg        rst_s1_reg;
  reg        rst_n;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Order: {pin b, pin a, external clocks}. Short pulses may be lost.
  wire [13:0] pin_raw = {compare_capture_pin_b_in,
                         compare_capture_pin_a_in, ext_clock_inputs};
  reg  [13:0] pin_s1_reg;
  reg  [13:0] pin_s2_reg;
  reg  [13:0] pin_s3_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 14'h0000;
      pin_s2_reg <= 14'h0000;
      pin_s3_reg <= 14'h0000;
    end
    else
    begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  wire [13:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire [13:0] pin_fall = ~pin_s2_reg & pin_s3_reg;
  wire [3:0]  ext_rise = pin_rise[3:0];
  wire [3:0]  ext_fall = pin_fall[3:0];

  // Quadrature decode of external clocks A and B.
  wire qa     = pin_s2_reg[0];
  wire qb     = pin_s2_reg[1];
  wire q_edge = ext_rise[0] | ext_fall[0] | ext_rise[1] | ext_fall[1];
  wire q_up   = (ext_rise[0] & ~qb) | (ext_fall[0] & qb) |
                (ext_rise[1] & qa) | (ext_fall[1] & ~qa);

  // ------------------------------------------------------------------
  // Global registers and prescaler
  // ------------------------------------------------------------------
  reg  [4:0] start_register;
  reg  [4:0] sync_reg;
  reg  [7:0] mode_reg;
  reg  [9:0] bufen_reg;
  reg  [2:0] presc_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_register <= 5'h00;
      sync_reg       <= 5'h00;
      mode_reg       <= `MCTU_RST_8;
      bufen_reg      <= 10'h000;
      presc_reg      <= 3'h0;
    end
    else
    begin
      presc_reg <= presc_reg + 3'h1;
      if (reg_wr && hit(reg_addr, `MCTU_GLOBAL_SEL, `MCTU_START_IDX))
        start_register <= reg_wdata[4:0];
      if (reg_wr && hit(reg_addr, `MCTU_GLOBAL_SEL, `MCTU_SYNC_IDX))
        sync_reg <= reg_wdata[4:0];
      if (reg_wr && hit(reg_addr, `MCTU_GLOBAL_SEL, `MCTU_MODE_IDX))
        mode_reg <= reg_wdata[7:0];
      if (reg_wr && hit(reg_addr, `MCTU_GLOBAL_SEL, `MCTU_BUFEN_IDX))
        bufen_reg <= reg_wdata[9:0];
    end
  end
  wire rs_mode = mode_reg[`MCTU_MODE_RSPWM];
  wire cp_mode = mode_reg[`MCTU_MODE_CPWM];
  wire sync_wr = reg_wr && (reg_addr[3:0] == `MCTU_CNT_IDX) &&
                 (reg_addr[7:4] < 4'h5) && sync_reg[reg_addr[6:4]];

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  wire [79:0] cnt_bus;
  wire [79:0] gra_bus;
  wire [79:0] grb_bus;
  wire [79:0] rd_bus;
  wire [4:0]  tick_bus;
  wire [4:0]  ma_bus;
  wire [4:0]  mb_bus;
  wire [4:0]  clr_bus;
  wire [4:0]  rev_bus;
  wire [4:0]  pa_bus;
  wire [4:0]  pb_bus;
  wire [4:0]  oea_bus;
  wire [4:0]  oeb_bus;
  wire [14:0] irq_bus;

  genvar ch;
  generate
    for (ch = 0; ch < 5; ch = ch + 1)
    begin : chan
      reg  [15:0] cnt_reg;
      reg  [15:0] gra_reg;
      reg  [15:0] grb_reg;
      reg  [15:0] bra_reg;
      reg  [15:0] brb_reg;
      reg  [7:0]  ctl_reg;
      reg  [7:0]  io_reg;
      reg  [2:0]  ien_reg;
      reg  [2:0]  flag_reg;
      reg  [2:0]  arm_reg;
      reg         dir_reg;
      reg         pa_reg;
      reg         pb_reg;
      reg  [15:0] rd_v;
      wire [3:0]  me = ch;
      wire [2:0]  cks = ctl_reg[`MCTU_CK_HI:`MCTU_CK_LO];
      wire [1:0]  edg = ctl_reg[`MCTU_EDGE_HI:`MCTU_EDGE_LO];
      wire [1:0]  csrc = ctl_reg[`MCTU_CLR_HI:`MCTU_CLR_LO];
      wire        phs = (ch == 2) && mode_reg[`MCTU_MODE_PHASE];
      wire        spc = (ch >= 3) && (rs_mode || cp_mode);
      wire        cmp = (ch >= 3) && cp_mode;
      wire        pwm = mode_reg[ch];
      wire        xr  = ext_rise[cks[1:0]];
      wire        xf  = ext_fall[cks[1:0]];
      wire        xe  = (edg == `MCTU_EDGE_RISE) ? xr :
                        (edg == `MCTU_EDGE_FALL) ? xf : (xr | xf);
      wire        src = cks[2] ? xe :
                        (cks == 3'h0) ? 1'b1 :
                        (cks == 3'h1) ? presc_reg[0] :
                        (cks == 3'h2) ? (&presc_reg[1:0]) :
                        (&presc_reg);
      wire        tick = start_register[ch] &&
                         (phs ? q_edge : src);
      wire        down = phs ? ~q_up : (cmp & dir_reg);
      // Channel 4 compares against counter 3 in reset-synced PWM.
      wire        iso  = (ch == 4) && rs_mode;
      wire [15:0] ccnt = iso ? cnt_bus[63:48] : cnt_reg;
      wire        ctk  = iso ? tick_bus[3] : tick;
      wire        a_oc = pwm | spc | ~io_reg[`MCTU_IOA_CAP];
      wire        b_oc = pwm | spc | ~io_reg[`MCTU_IOB_CAP];
      // Match fires on the count edge that leaves the equal value.
      wire        ma = ctk & a_oc & (ccnt == gra_reg);
      wire        mb = ctk & b_oc & (ccnt == grb_reg);
      wire        ar = pin_rise[4 + ch];
      wire        af = pin_fall[4 + ch];
      wire        br = pin_rise[9 + ch];
      wire        bf = pin_fall[9 + ch];
      wire        ca = ~a_oc & ((io_reg[1:0] == 2'h0) ? ar :
                       (io_reg[1:0] == 2'h1) ? af : (ar | af));
      wire        cb = ~b_oc & ((io_reg[5:4] == 2'h0) ? br :
                       (io_reg[5:4] == 2'h1) ? bf : (br | bf));
      wire        own_clr = ~cmp & (((csrc == `MCTU_CLR_A) & (ma | ca)) |
                            ((csrc == `MCTU_CLR_B) & (mb | cb)));
      wire        sclr = sync_reg[ch] & (csrc == `MCTU_CLR_SYNC) &
                         (|(clr_bus & sync_reg & ~(5'h01 << ch)));
      wire        wr_cnt = reg_wr & hit(reg_addr, me, `MCTU_CNT_IDX);
      wire        load = wr_cnt | (sync_reg[ch] & sync_wr);
      wire        edge_v = down ? (cnt_reg == `MCTU_CNT_ZERO) :
                           (cnt_reg == (cmp ? gra_bus[63:48] : `MCTU_CNT_TOP));
      wire        turn = cmp & edge_v;
      wire        ovf = tick & ~load & ~own_clr & ~sclr & (down ?
                        (cnt_reg == `MCTU_CNT_ZERO) :
                        (cnt_reg == `MCTU_CNT_TOP));
      wire        xfer = cp_mode ? rev_bus[3] :
                         rs_mode ? ma_bus[3] : 1'b1;
      wire        bua = bufen_reg[ch] & ~a_oc;
      wire        bub = bufen_reg[`MCTU_BUFB_LO + ch] & ~b_oc;
      wire        xa  = bufen_reg[ch] & a_oc & xfer &
                        ((ch >= 3 && (cp_mode || rs_mode)) ? 1'b1 : ma);
      wire        xb  = bufen_reg[`MCTU_BUFB_LO + ch] & b_oc & xfer &
                        ((ch >= 3 && (cp_mode || rs_mode)) ? 1'b1 : mb);
      wire        st_wr = reg_wr & hit(reg_addr, me, `MCTU_STAT_IDX);
      wire        st_rd = reg_rd & hit(reg_addr, me, `MCTU_STAT_IDX);
      wire [2:0]  fset = {ovf, mb | cb, ma | ca};
      wire [2:0]  fclr = {3{st_wr}} & ~reg_wdata[2:0] & arm_reg;
      wire [2:0]  fnext = fset | (flag_reg & ~fclr);
      wire        io_wr = reg_wr & hit(reg_addr, me, `MCTU_IOCTL_IDX);

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_reg  <= `MCTU_RST_16;
          gra_reg  <= `MCTU_CNT_TOP;
          grb_reg  <= `MCTU_CNT_TOP;
          bra_reg  <= `MCTU_CNT_TOP;
          brb_reg  <= `MCTU_CNT_TOP;
          ctl_reg  <= `MCTU_RST_8;
          io_reg   <= `MCTU_RST_8;
          ien_reg  <= 3'h0;
          flag_reg <= 3'h0;
          arm_reg  <= 3'h0;
          dir_reg  <= 1'b0;
          pa_reg   <= 1'b0;
          pb_reg   <= 1'b0;
        end
        else
        begin
          if (reg_wr && hit(reg_addr, me, `MCTU_CTRL_IDX))
            ctl_reg <= reg_wdata[7:0];
          if (io_wr)
            io_reg <= reg_wdata[7:0];
          if (reg_wr && hit(reg_addr, me, `MCTU_IRQEN_IDX))
            ien_reg <= reg_wdata[2:0];
          flag_reg <= fnext;
          arm_reg  <= (st_rd ? flag_reg : arm_reg) & fnext;
          if (load)
            cnt_reg <= reg_wdata;
          else if (own_clr || sclr)
            cnt_reg <= `MCTU_CNT_ZERO;
          else if (tick)
          begin
            if (turn)
              dir_reg <= ~dir_reg;
            cnt_reg <= (down ^ turn) ? cnt_reg - 16'h0001 :
                       cnt_reg + 16'h0001;
          end
          if (reg_wr && hit(reg_addr, me, `MCTU_GRA_IDX))
            gra_reg <= reg_wdata;
          else if (ca)
            gra_reg <= cnt_reg;
          else if (xa)
            gra_reg <= bra_reg;
          if (reg_wr && hit(reg_addr, me, `MCTU_GRB_IDX))
            grb_reg <= reg_wdata;
          else if (cb)
            grb_reg <= cnt_reg;
          else if (xb)
            grb_reg <= brb_reg;
          if (reg_wr && hit(reg_addr, me, `MCTU_BRA_IDX))
            bra_reg <= reg_wdata;
          else if (ca && bua)
            bra_reg <= gra_reg;
          if (reg_wr && hit(reg_addr, me, `MCTU_BRB_IDX))
            brb_reg <= reg_wdata;
          else if (cb && bub)
            brb_reg <= grb_reg;
          // Reconfiguring the pin restarts it from 0.
          if (io_wr)
            pa_reg <= 1'b0;
          else if (pwm)
          begin
            if (ma && !mb)
              pa_reg <= 1'b1;
            else if (mb && !ma)
              pa_reg <= 1'b0;
          end
          else if (ma)
          begin
            case (io_reg[1:0])
              `MCTU_OUT_LOW:    pa_reg <= 1'b0;
              `MCTU_OUT_HIGH:   pa_reg <= 1'b1;
              `MCTU_OUT_TOGGLE: pa_reg <= (ch == 2) ? pa_reg : ~pa_reg;
              default:          pa_reg <= pa_reg;
            endcase
          end
          if (io_wr)
            pb_reg <= 1'b0;
          else if (mb)
          begin
            case (io_reg[5:4])
              `MCTU_OUT_LOW:    pb_reg <= 1'b0;
              `MCTU_OUT_HIGH:   pb_reg <= 1'b1;
              `MCTU_OUT_TOGGLE: pb_reg <= (ch == 2) ? pb_reg : ~pb_reg;
              default:          pb_reg <= pb_reg;
            endcase
          end
        end
      end

      always @*
      begin
        rd_v = 16'h0000;
        case (reg_addr[3:0])
          `MCTU_CTRL_IDX:  rd_v = {8'h00, ctl_reg};
          `MCTU_IOCTL_IDX: rd_v = {8'h00, io_reg};
          `MCTU_IRQEN_IDX: rd_v = `MCTU_STAT_RSV | {13'h0000, ien_reg};
          `MCTU_STAT_IDX:  rd_v = `MCTU_STAT_RSV | {13'h0000, flag_reg};
          `MCTU_CNT_IDX:   rd_v = cnt_reg;
          `MCTU_GRA_IDX:   rd_v = gra_reg;
          `MCTU_GRB_IDX:   rd_v = grb_reg;
          `MCTU_BRA_IDX:   rd_v = bra_reg;
          `MCTU_BRB_IDX:   rd_v = brb_reg;
          default:         rd_v = 16'h0000;
        endcase
      end

      assign cnt_bus[ch*16 +: 16] = cnt_reg;
      assign gra_bus[ch*16 +: 16] = gra_reg;
      assign grb_bus[ch*16 +: 16] = grb_reg;
      assign rd_bus[ch*16 +: 16]  = rd_v;
      assign tick_bus[ch] = tick;
      assign ma_bus[ch]   = ma;
      assign mb_bus[ch]   = mb;
      assign clr_bus[ch]  = own_clr;
      assign rev_bus[ch]  = tick & turn;
      assign pa_bus[ch]   = pa_reg;
      assign pb_bus[ch]   = pb_reg;
      assign oea_bus[ch]  = a_oc & (pwm | (io_reg[1:0] != 2'h0));
      assign oeb_bus[ch]  = b_oc & (io_reg[5:4] != 2'h0);
      assign irq_bus[ch*3 +: 3] = flag_reg & ien_reg;
    end
  endgenerate

  // ------------------------------------------------------------------
  // Channel 3/4 PWM pairs and registered outputs
  // ------------------------------------------------------------------
  // Reset-synced pairs go high at the cycle reset, low at their match.
  reg  [2:0]  rsp_reg;
  wire [47:0] pair_gr = {grb_bus[79:64], gra_bus[79:64], grb_bus[63:48]};
  wire [15:0] c3 = cnt_bus[63:48];
  wire [15:0] c4 = cnt_bus[79:64];
  wire [2:0]  rs_fall = {mb_bus[4], ma_bus[4], mb_bus[3]};
  reg  [2:0]  pos_v;
  reg  [2:0]  neg_v;
  integer k;
  always @*
  begin
    pos_v = rsp_reg;
    neg_v = ~rsp_reg;
    if (cp_mode)
    begin
      // Counter 4 trails counter 3, so both tests can never hold at once.
      for (k = 0; k < 3; k = k + 1)
      begin
        pos_v[k] = (c3 > pair_gr[k*16 +: 16]) && (c4 > pair_gr[k*16 +: 16]);
        neg_v[k] = (c3 < pair_gr[k*16 +: 16]) && (c4 < pair_gr[k*16 +: 16]);
      end
    end
  end
  wire spc_out = rs_mode | cp_mode;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_reg                   <= 3'h0;
      reg_rdata                 <= 16'h0000;
      compare_capture_pin_a_out <= 5'h00;
      compare_capture_pin_a_oe  <= 5'h00;
      compare_capture_pin_b_out <= 5'h00;
      compare_capture_pin_b_oe  <= 5'h00;
      ch4_inverse_out_a         <= 1'b0;
      ch4_inverse_out_b         <= 1'b0;
      irq_req                   <= 15'h0000;
    end
    else
    begin
      if (!rs_mode)
        rsp_reg <= 3'h0;
      else if (ma_bus[3])
        rsp_reg <= 3'h7;
      else
        rsp_reg <= rsp_reg & ~rs_fall;
      if (!reg_rd)
        reg_rdata <= 16'h0000;
      else if (reg_addr[7:4] < 4'h5)
        reg_rdata <= rd_bus[reg_addr[6:4]*16 +: 16];
      else
        reg_rdata <= 16'h0000;
      irq_req <= irq_bus;
      compare_capture_pin_a_out <= spc_out ?
        {pos_v[1], pos_v[0], pa_bus[2:0]} : pa_bus;
      compare_capture_pin_b_out <= spc_out ?
        {pos_v[2], neg_v[0], pb_bus[2:0]} : pb_bus;
      compare_capture_pin_a_oe <= spc_out ?
        {2'h3, oea_bus[2:0]} : oea_bus;
      compare_capture_pin_b_oe <= spc_out ?
        {2'h3, oeb_bus[2:0]} : oeb_bus;
      ch4_inverse_out_a <= spc_out & neg_v[1];
      ch4_inverse_out_b <= spc_out & neg_v[2];
    end
  end
endmodule // mctu_timer
`default_nettype wire

// *** verif/mctu_chk.sv ***
// Port-level assertions for the five-channel timer unit.
`timescale 1ns/100ps
`default_nettype none
module mctu_chk
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [4:0]  compare_capture_pin_a_out,
  input wire logic [4:0]  compare_capture_pin_b_out,
  input wire logic        ch4_inverse_out_a,
  input wire logic        ch4_inverse_out_b,
  input wire logic [14:0] irq_req
);
  logic [7:0] mode_reg;
  logic [2:0] en0_reg;
  logic [2:0] io2_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Shadows of software writes, so the checker knows the modes.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_reg <= 8'h00;
      en0_reg <= 3'h0;
      io2_reg <= 3'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h52)
        mode_reg <= reg_wdata[7:0];
      if (reg_addr == 8'h02)
        en0_reg <= reg_wdata[2:0];
      if (reg_addr == 8'h21)
        io2_reg <= reg_wdata[2:0];
    end
  end
  irq_fall_a:
    assert property (|($past(irq_req) & ~irq_req) |->
      $past(reg_wr) || $past(reg_wr, 2)) else $error("irq fell unasked");
  irq_en_a:
    assert property ((irq_req[2:0] & ~en0_reg & ~$past(en0_reg)) == 3'h0)
      else $error("masked irq raised");
  io_clr_a:
    assert property (reg_wr && reg_addr == 8'h01 && !mode_reg[0] |=>
      ##1 !compare_capture_pin_a_out[0]) else $error("pin not 0 on setup");
  ch2_tog_a:
    assert property (io2_reg == 3'h3 && $past(io2_reg) == 3'h3 &&
      !mode_reg[2] |-> $stable(compare_capture_pin_a_out[2]))
      else $error("channel 2 pin toggled");
  stat_rsv_a:
    assert property (reg_rd && reg_addr[3:0] == 4'h3 &&
      reg_addr[7:4] < 4'h5 |=> reg_rdata[6:3] == 4'hF)
      else $error("status reserved bits");
  cpwm_gap_a:
    assert property (mode_reg[7] && $past(mode_reg[7]) |->
      !(compare_capture_pin_a_out[3] && compare_capture_pin_b_out[3]) &&
      !(compare_capture_pin_a_out[4] && ch4_inverse_out_a) &&
      !(compare_capture_pin_b_out[4] && ch4_inverse_out_b))
      else $error("pair overlap");
  rspwm_inv_a:
    assert property (mode_reg[6] && $past(mode_reg[6]) &&
      $past(mode_reg[6], 2) |-> compare_capture_pin_b_out[3] ==
      !compare_capture_pin_a_out[3]) else $error("pair not inverse");
  inv_idle_a:
    assert property (mode_reg[7:6] == 2'h0 && $past(mode_reg[7:6]) == 2'h0
      |-> !ch4_inverse_out_a && !ch4_inverse_out_b)
      else $error("inverse out active");
endmodule // mctu_chk
bind mctu_timer mctu_chk chk_u
(
  .clk                       (clk),
  .rst_b                     (rst_b),
  .reg_addr                  (reg_addr),
  .reg_wdata                 (reg_wdata),
  .reg_wr                    (reg_wr),
  .reg_rd                    (reg_rd),
  .reg_rdata                 (reg_rdata),
  .compare_capture_pin_a_out (compare_capture_pin_a_out),
  .compare_capture_pin_b_out (compare_capture_pin_b_out),
  .ch4_inverse_out_a         (ch4_inverse_out_a),
  .ch4_inverse_out_b         (ch4_inverse_out_b),
  .irq_req                   (irq_req)
);
`default_nettype wire

// *** verif/mctu_pins.sv ***
// Pulse sources standing in for the timer's external pins.
`timescale 1ns/100ps
`default_nettype none
module mctu_pins
(
  input  wire logic       clk,
  output var  logic [3:0] ext_clk,
  output var  logic [4:0] cap_a
);
  initial
  begin
    ext_clk = 4'h0;
    cap_a = 5'h00;
  end
  // Each level lasts three clocks, above the shortest pulse that is
  // counted reliably, so both-edge counting stays exact.
  task automatic clk_pulses(input int n);
    repeat (2 * n)
    begin
      repeat (3) @(posedge clk);
      ext_clk[0] <= ~ext_clk[0];
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic cap_rise(input int ch);
    repeat (3) @(posedge clk);
    cap_a[ch] <= 1'b1;
    repeat (6) @(posedge clk);
    cap_a[ch] <= 1'b0;
  endtask
endmodule // mctu_pins
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the five-channel timer unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  ext_clk;
  logic [4:0]  cap_a;
  logic [4:0]  pa_out;
  logic [4:0]  pb_out;
  logic [4:0]  pa_oe;
  logic        inv_a;
  logic        inv_b;
  logic [14:0] irq_req;
  logic [15:0] v;
  logic [15:0] r;
  int          n_mismatch;
  int          n_tests;
  int          n;
  int          k;
  mctu_timer dut_u
  (
    .clk                       (clk),
    .rst_b                     (rst_b),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .ext_clock_inputs          (ext_clk),
    .compare_capture_pin_a_in  (cap_a),
    .compare_capture_pin_a_out (pa_out),
    .compare_capture_pin_a_oe  (pa_oe),
    .compare_capture_pin_b_in  (cap_a),
    .compare_capture_pin_b_out (pb_out),
    .compare_capture_pin_b_oe  (),
    .ch4_inverse_out_a         (inv_a),
    .ch4_inverse_out_b         (inv_b),
    .irq_req                   (irq_req)
  );
  mctu_pins pins_u (.clk(clk), .ext_clk(ext_clk), .cap_a(cap_a));
  always #50 clk = ~clk;
  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // A hang on a missing request ends the run as a mismatch.
  task automatic wait_irq(input int b);
    int i;
    for (i = 0; i < 2000 && irq_req[b] !== 1'b1; i++)
      @(negedge clk);
    if (i == 2000)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    v = 16'($urandom(32'h683B));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h03, v); chk(v, 16'h0078);
    rd(8'h02, v); chk(v, 16'h0078);
    rd(8'h05, v); chk(v, 16'hFFFF);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h00, 16'(s));
      wr(8'h04, 16'h0000);
      wr(8'h50, 16'h0001);
      repeat (64) @(posedge clk);
      wr(8'h50, 16'h0000);
      rd(8'h04, v);
      n = 66 >> s;
      chk({15'h0, v + 2 >= n && v <= n + 2}, 16'h0001);
      rd(8'h04, r); chk(r, v);
    end
    for (int g = 0; g < 3; g++)
    begin
      n = $urandom_range(6, 3);
      wr(8'h00, 16'h0004 | 16'(g << 3));
      wr(8'h04, 16'h0000);
      wr(8'h50, 16'h0001);
      pins_u.clk_pulses(n);
      wr(8'h50, 16'h0000);
      rd(8'h04, v); chk(v, 16'((g == 2) ? 2 * n : n));
    end
    wr(8'h00, 16'h0020);
    wr(8'h01, 16'h0002);
    wr(8'h05, 16'h0003);
    wr(8'h02, 16'h0001);
    wr(8'h04, 16'h0000);
    chk({15'h0, pa_out[0]}, 16'h0000);
    chk({15'h0, pa_oe[0]}, 16'h0001);
    wr(8'h50, 16'h0001);
    wait_irq(0);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, pa_out[0]}, 16'h0001);
    wr(8'h50, 16'h0000);
    rd(8'h04, v); chk({15'h0, v <= 16'h0003}, 16'h0001);
    rd(8'h03, v); chk(v, 16'h0079);
    wr(8'h03, 16'h007F);
    repeat (2) @(posedge clk);
    chk({15'h0, irq_req[0]}, 16'h0001);
    wr(8'h03, 16'h0078);
    repeat (2) @(posedge clk);
    chk({15'h0, irq_req[0]}, 16'h0000);
    wr(8'h02, 16'h0000);
    wr(8'h50, 16'h0001);
    repeat (20) @(posedge clk);
    wr(8'h50, 16'h0000);
    chk({15'h0, irq_req[0]}, 16'h0000);
    rd(8'h03, v); chk(v, 16'h0079);
    chk({15'h0, pa_out[0]}, 16'h0001);
    wr(8'h12, 16'h0004);
    wr(8'h14, 16'hFFFD);
    wr(8'h50, 16'h0002);
    wait_irq(5);
    wr(8'h50, 16'h0000);
    rd(8'h14, v); chk({15'h0, v < 16'h0010}, 16'h0001);
    rd(8'h13, v); chk(v, 16'h007F);
    wr(8'h11, 16'h0004);
    wr(8'h14, 16'h0000);
    wr(8'h50, 16'h0002);
    pins_u.cap_rise(1);
    wr(8'h50, 16'h0000);
    rd(8'h15, v);
    rd(8'h14, r);
    chk({15'h0, v >= 16'h0002 && v < r}, 16'h0001);
    wr(8'h51, 16'h0003);
    v = 16'($urandom);
    wr(8'h04, v);
    rd(8'h14, r); chk(r, v);
    wr(8'h10, 16'h0060);
    wr(8'h04, 16'h0000);
    wr(8'h50, 16'h0003);
    repeat (50) @(posedge clk);
    wr(8'h50, 16'h0000);
    rd(8'h14, v); chk({15'h0, v <= 16'h0003}, 16'h0001);
    wr(8'h51, 16'h0000);
    wr(8'h00, 16'h0040);
    wr(8'h05, 16'h0002);
    wr(8'h06, 16'h0006);
    wr(8'h04, 16'h0000);
    wr(8'h52, 16'h0001);
    wr(8'h50, 16'h0001);
    k = 0;
    repeat (42)
    begin
      @(posedge clk);
      #1 k = k + pa_out[0];
    end
    chk({15'h0, k >= 21 && k <= 27}, 16'h0001);
    wr(8'h50, 16'h0000);
    wr(8'h20, 16'h0020);
    wr(8'h21, 16'h0003);
    wr(8'h25, 16'h0001);
    wr(8'h50, 16'h0004);
    repeat (20) @(posedge clk);
    chk({15'h0, pa_out[2]}, 16'h0000);
    wr(8'h20, 16'h0000);
    wr(8'h52, 16'h0020);
    wr(8'h24, 16'h0000);
    pins_u.clk_pulses(n);
    rd(8'h24, v); chk(v, 16'h0000);
    wr(8'h52, 16'h0080);
    wr(8'h50, 16'h0018);
    repeat (30) @(posedge clk);
    wr(8'h52, 16'h0040);
    repeat (30) @(posedge clk);
    #1 chk({15'h0, pa_out[3] ^ pb_out[3]}, 16'h0001);
    wr(8'h50, 16'h0000);
    wr(8'h52, 16'h0000);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
